// [verilog/smbus_monitor_top.sv]
// smbus slave front end: address straps, pointer, registers, alert
// Function
// - Address-enable strap low at power-up selects address from select pin.
// - Address-enable strap high gives fixed address 0x2E.
// - Seven-bit slave address decoded from each transaction's first byte.
// - Both strap pin levels sampled from power-up to choose addressing.
// - Address latched on eighth clock rise of first matching address byte.
// - After latching, strap changes ignored until power is removed.
// - Device is a bus slave only; the master does all control.
// - First data byte of every write loads the register pointer.
// - Alert pin pulled low while any unmasked status bit is set.
// - Each status event has a mask bit that blocks the alert.
// - Each channel's high and low limit comparisons share one readable out-of-limit status bit.
// - Once started, measurements cycle repeatedly through all inputs.
// - Stored values compared with limits, outcome kept in status.
// - Temperature readings adjusted by signed per-channel offset register.
// - Config one bit 7 selects 5 V supply scaling instead of 3.3 V.
// - Either of two pins can be configured as the alert output.
// - Select pin may serve as two-way overtemperature line.
// - Select mode addresses are 0x2C with pin low, 0x2D with it high.
// - A read returns the register chosen by the pointer.
// - A second write byte is stored in the pointed register.
`timescale 1ns/1ps
module smbus_monitor_top
  import smbus_mon_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDR_ENABLE_IN,
  input wire logic ADDR_SELECT_IN,
  output logic ADDR_SELECT_OUT,
  output logic ADDR_SELECT_OE,
  output logic ALERT_FIVE_OUT,
  output logic ALERT_FIVE_OE,
  output logic ALERT_MON_OUT,
  output logic ALERT_MON_OE,
  input wire logic MEAS_VALID,
  input wire logic [7:0] MEAS_VALUE,
  output logic [2:0] MEAS_CHANNEL,
  output logic SUPPLY_SCALE_5V
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PTR, S_DATA, S_READ, S_SKIP
  } proto_state_t;

  function automatic logic in_block(input logic [7:0] p,
                                    input logic [7:0] base,
                                    input logic [7:0] n);
    in_block = (p >= base) && (p < base + n);
  endfunction

  smbus_link_if lk();
  proto_state_t state;
  proto_state_t next_state;
  logic [1:0] strap_en_sync;
  logic [1:0] strap_sel_sync;
  logic strap_en;
  logic strap_sel;
  logic latched;
  logic [6:0] addr_latched;
  logic [7:0] ptr;
  logic [7:0] tx;
  logic [7:0] rd_data;
  logic [7:0] config_one;
  logic [7:0] pin_cfg;
  logic [7:0] mask;
  logic [7:0] therm_time;
  logic [7:0] tick_cnt;
  logic [NUM_CH-1:0][7:0] high_lim;
  logic [NUM_CH-1:0][7:0] low_lim;
  logic [NUM_CH-1:0][7:0] values;
  logic [NUM_TEMP-1:0][7:0] offsets;
  logic [NUM_CH-1:0] over_hi;
  logic [NUM_CH-1:0] over_lo;
  logic ack_pend;
  logic alert_a;
  logic alert_b;
  logic therm_drive;

  smbus_link u_link (
    .clk(CLK_SYS),
    .rst(RESET),
    .scl_pin(SCL_IN),
    .sda_pin(SDA_IN),
    .sda_oe(SDA_OE),
    .lk(lk)
  );

  measurement_sequencer u_seq (
    .clk(CLK_SYS),
    .rst(RESET),
    .run(config_one[CFG_START_BIT]),
    .meas_valid(MEAS_VALID),
    .meas_value(MEAS_VALUE),
    .offsets(offsets),
    .high_lim(high_lim),
    .low_lim(low_lim),
    .channel(MEAS_CHANNEL),
    .values(values),
    .over_hi(over_hi),
    .over_lo(over_lo)
  );

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      strap_en_sync <= 2'h3;
      strap_sel_sync <= 2'h3;
      strap_en <= 1'b1;
      strap_sel <= 1'b1;
    end else begin
      strap_en_sync <= {strap_en_sync[0], ADDR_ENABLE_IN};
      strap_sel_sync <= {strap_sel_sync[0], ADDR_SELECT_IN};
      if (!latched) begin
        strap_en <= strap_en_sync[1];
        strap_sel <= strap_sel_sync[1];
      end
    end
  end

  wire [6:0] live_addr =
    strap_en ? ADDR_DEFAULT : (ADDR_SEL_BASE | {6'h00, strap_sel});
  wire [6:0] sel_addr = latched ? addr_latched : live_addr;
  wire addr_match = (lk.rx_byte[7:1] == sel_addr);
  wire is_read = lk.rx_byte[0];
  wire addr_byte = lk.byte_done && (state == S_ADDR);
  wire latch_now = addr_byte && addr_match && !latched;
  wire rd_load = (addr_byte && addr_match && is_read) ||
    (lk.ninth_done && state == S_READ && !lk.ack_bit);
  wire wr_en = lk.byte_done && (state == S_DATA);
  wire [7:0] wr_data = lk.rx_byte;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      latched <= 1'b0;
      addr_latched <= ADDR_DEFAULT;
    end else if (latch_now) begin
      latched <= 1'b1;
      addr_latched <= sel_addr;
    end
  end

  always_comb begin
    next_state = state;
    if (lk.stop) begin
      next_state = S_IDLE;
    end else if (lk.start) begin
      next_state = S_ADDR;
    end else if (lk.byte_done) begin
      case (state)
        S_ADDR: begin
          if (!addr_match) next_state = S_SKIP;
          else if (is_read) next_state = S_READ;
          else next_state = S_PTR;
        end
        S_PTR: next_state = S_DATA;
        S_DATA: next_state = S_SKIP;
        default: next_state = state;
      endcase
    end else if (lk.ninth_done && state == S_READ && lk.ack_bit) begin
      next_state = S_SKIP;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) state <= S_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET || lk.start || lk.stop || lk.ninth_done) begin
      ack_pend <= 1'b0;
    end else if (lk.byte_done) begin
      ack_pend <= (state == S_ADDR) ? addr_match :
        (state == S_PTR) || (state == S_DATA);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) ptr <= 8'h00;
    else if (lk.byte_done && state == S_PTR) ptr <= lk.rx_byte;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) tx <= 8'h00;
    else if (rd_load) tx <= rd_data;
  end

  // data bits change on the falling clock only
  wire tx_bit = tx[3'(LAST_DATA_BIT - lk.bit_cnt)];
  wire next_sda_low = (lk.bit_cnt == ACK_SLOT) ? ack_pend :
    (state == S_READ) && !lk.bit_cnt[3] && !tx_bit;

  always_ff @(posedge CLK_SYS) begin
    if (RESET || lk.start || lk.stop) lk.sda_low <= 1'b0;
    else if (lk.scl_fall) lk.sda_low <= next_sda_low;
  end

  wire hit_value = in_block(ptr, REG_VALUE_BASE, 8'(NUM_CH));
  wire hit_high = in_block(ptr, REG_HIGH_BASE, 8'(NUM_CH));
  wire hit_low = in_block(ptr, REG_LOW_BASE, 8'(NUM_CH));
  wire hit_off = in_block(ptr, REG_OFFSET_BASE, 8'(NUM_TEMP));
  wire [7:0] idx_value = ptr - REG_VALUE_BASE;
  wire [7:0] idx_high = ptr - REG_HIGH_BASE;
  wire [7:0] idx_low = ptr - REG_LOW_BASE;
  wire [7:0] idx_off = ptr - REG_OFFSET_BASE;

  wire therm_en = pin_cfg[PIN_THERM_BIT] && latched;
  wire therm_active = therm_en && !strap_sel_sync[1] && !therm_drive;
  wire [7:0] status = 8'(over_hi | over_lo) |
    (8'(therm_active) << STATUS_THERM_BIT);
  wire alert_active = |(status & ~mask);

  always_comb begin
    rd_data = 8'h00;
    if (hit_value) rd_data = values[idx_value[2:0]];
    else if (hit_high) rd_data = high_lim[idx_high[2:0]];
    else if (hit_low) rd_data = low_lim[idx_low[2:0]];
    else if (hit_off) rd_data = offsets[idx_off[1:0]];
    else if (ptr == REG_CONFIG_ONE) rd_data = config_one;
    else if (ptr == REG_STATUS) rd_data = status;
    else if (ptr == REG_MASK) rd_data = mask;
    else if (ptr == REG_PIN_CFG) rd_data = pin_cfg;
    else if (ptr == REG_THERM_TIME) rd_data = therm_time;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      config_one <= CONFIG_ONE_RESET;
      pin_cfg <= PIN_CFG_RESET;
      mask <= MASK_RESET;
    end else if (wr_en) begin
      if (ptr == REG_CONFIG_ONE) config_one <= wr_data;
      if (ptr == REG_PIN_CFG) pin_cfg <= wr_data;
      if (ptr == REG_MASK) mask <= wr_data;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int i = 0; i < NUM_CH; i++) begin
        high_lim[i] <= (i >= TEMP_FIRST) ? TEMP_HIGH_RESET : VOLT_HIGH_RESET;
        low_lim[i] <= (i >= TEMP_FIRST) ? TEMP_LOW_RESET : VOLT_LOW_RESET;
      end
      for (int i = 0; i < NUM_TEMP; i++) begin
        offsets[i] <= OFFSET_RESET;
      end
    end else if (wr_en) begin
      if (hit_high) high_lim[idx_high[2:0]] <= wr_data;
      if (hit_low) low_lim[idx_low[2:0]] <= wr_data;
      if (hit_off) offsets[idx_off[1:0]] <= wr_data;
    end
  end

  // overtemperature input timer, cleared by reading it
  wire tick = therm_active && (tick_cnt == 8'(THERM_TICK_CYCLES - 1));
  wire therm_clear = rd_load && (ptr == REG_THERM_TIME);
  wire [7:0] therm_base = therm_clear ? 8'h00 : therm_time;

  always_ff @(posedge CLK_SYS) begin
    if (RESET || !therm_active || tick) tick_cnt <= 8'h00;
    else tick_cnt <= tick_cnt + 8'h01;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) therm_time <= 8'h00;
    else if (tick && therm_base != 8'hff) therm_time <= therm_base + 8'h01;
    else therm_time <= therm_base;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) therm_drive <= 1'b0;
    else therm_drive <= therm_en && |over_hi[NUM_CH-1:TEMP_FIRST];
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      alert_a <= 1'b0;
      alert_b <= 1'b0;
    end else begin
      alert_a <= pin_cfg[PIN_ALERT_FIVE_BIT] && alert_active;
      alert_b <= pin_cfg[PIN_ALERT_MON_BIT] && alert_active;
    end
  end

  assign SDA_OUT = 1'b0;
  assign ADDR_SELECT_OUT = 1'b0;
  assign ADDR_SELECT_OE = therm_drive;
  assign ALERT_FIVE_OUT = 1'b0;
  assign ALERT_FIVE_OE = alert_a;
  assign ALERT_MON_OUT = 1'b0;
  assign ALERT_MON_OE = alert_b;
  assign SUPPLY_SCALE_5V = config_one[CFG_VCC5_BIT];

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  property p_default_addr;
    !latched && strap_en |-> sel_addr == ADDR_DEFAULT;
  endproperty
  a_default_addr: assert property (p_default_addr)
    else $error("default address not used with enable strap high");

  property p_select_addr;
    !latched && !strap_en && strap_sel |-> sel_addr == ADDR_SEL_BASE + 7'h1;
  endproperty
  a_select_addr: assert property (p_select_addr)
    else $error("select mode address wrong with select pin high");

  property p_latch;
    latch_now |=> latched && addr_latched == $past(sel_addr);
  endproperty
  a_latch: assert property (p_latch)
    else $error("address not latched on first matching byte");

  property p_hold;
    latched |=> latched && $stable(addr_latched) && $stable(strap_en);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address or strap changed after latching");

  property p_ptr;
    lk.byte_done && state == S_PTR |=> ptr == $past(lk.rx_byte);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("first write byte not loaded into pointer");

  property p_write;
    wr_en && ptr == REG_MASK |=> mask == $past(wr_data) ##1 $stable(mask);
  endproperty
  a_write: assert property (p_write)
    else $error("second write byte not stored in pointed register");

  property p_readback;
    addr_byte && addr_match && is_read
      |=> tx == $past(rd_data) && state == S_READ;
  endproperty
  a_readback: assert property (p_readback)
    else $error("read did not load the pointed register");

  property p_foreign;
    addr_byte && !addr_match |=> !ack_pend && state == S_SKIP;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign address acknowledged");

  property p_alert;
    pin_cfg[PIN_ALERT_FIVE_BIT] && alert_active |=> ALERT_FIVE_OE;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert not asserted for unmasked status");

  property p_release;
    (status & ~mask) == 8'h00 |=> !ALERT_FIVE_OE && !ALERT_MON_OE;
  endproperty
  a_release: assert property (p_release)
    else $error("alert held with no unmasked status");

  property p_idle_quiet;
    state == S_IDLE |=> !SDA_OE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("sda driven outside a transaction");

  c_latch: cover property (latch_now);
  c_read_ack: cover property (rd_load ##[1:300] lk.ninth_done);
  c_write: cover property (wr_en && ptr == REG_CONFIG_ONE);
  c_alert: cover property ($rose(ALERT_FIVE_OE));
endmodule // smbus_monitor_top

// [verilog/smbus_mon_pkg.sv]
// constants for the smbus monitor front end
package smbus_mon_pkg;
  localparam logic [6:0] ADDR_DEFAULT = 7'h2e;
  localparam logic [6:0] ADDR_SEL_BASE = 7'h2c;
  localparam logic [7:0] REG_VALUE_BASE = 8'h20;
  localparam logic [7:0] REG_CONFIG_ONE = 8'h40;
  localparam logic [7:0] REG_STATUS = 8'h41;
  localparam logic [7:0] REG_HIGH_BASE = 8'h44;
  localparam logic [7:0] REG_LOW_BASE = 8'h50;
  localparam logic [7:0] REG_OFFSET_BASE = 8'h70;
  localparam logic [7:0] REG_MASK = 8'h74;
  localparam logic [7:0] REG_THERM_TIME = 8'h79;
  localparam logic [7:0] REG_PIN_CFG = 8'h7c;
  localparam int NUM_CH = 5;
  localparam int NUM_TEMP = 3;
  localparam int TEMP_FIRST = 2;
  localparam int CFG_START_BIT = 0;
  localparam int CFG_VCC5_BIT = 7;
  localparam int PIN_ALERT_FIVE_BIT = 0;
  localparam int PIN_ALERT_MON_BIT = 1;
  localparam int PIN_THERM_BIT = 2;
  localparam int STATUS_THERM_BIT = 5;
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
  localparam logic [7:0] PIN_CFG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] VOLT_HIGH_RESET = 8'hff;
  localparam logic [7:0] VOLT_LOW_RESET = 8'h00;
  localparam logic [7:0] TEMP_HIGH_RESET = 8'h7f;
  localparam logic [7:0] TEMP_LOW_RESET = 8'h80;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam int CLK_PERIOD_NS = 4;
  localparam int THERM_TICK_NS = 1000;
  localparam int THERM_TICK_CYCLES =
    (THERM_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
endpackage

// [verilog/smbus_link_if.sv]
// bit level events passed from the smbus link to the protocol logic
`timescale 1ns/1ps
interface smbus_link_if;
  logic start;
  logic stop;
  logic byte_done;
  logic ninth_done;
  logic ack_bit;
  logic scl_fall;
  logic [3:0] bit_cnt;
  logic [7:0] rx_byte;
  logic sda_low;
  modport link (output start, stop, byte_done, ninth_done, ack_bit,
    scl_fall, bit_cnt, rx_byte, input sda_low);
  modport proto (input start, stop, byte_done, ninth_done, ack_bit,
    scl_fall, bit_cnt, rx_byte, output sda_low);
endinterface

// [verilog/smbus_link.sv]
// smbus pin synchroniser, start/stop detection and bit shifter
`timescale 1ns/1ps
module smbus_link
  import smbus_mon_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe,
  smbus_link_if.link lk
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic [6:0] shift;
  wire scl_now = scl_sync[1];
  wire sda_now = sda_sync[1];
  wire rise = scl_now & ~scl_prev;
  wire start_seen = scl_now & scl_prev & sda_prev & ~sda_now;
  wire stop_seen = scl_now & scl_prev & ~sda_prev & sda_now;
  wire last_bit = (lk.bit_cnt == LAST_DATA_BIT);
  wire ack_slot = (lk.bit_cnt == ACK_SLOT);

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_pin};
      sda_sync <= {sda_sync[0], sda_pin};
      scl_prev <= scl_now;
      sda_prev <= sda_now;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lk.start <= 1'b0;
      lk.stop <= 1'b0;
      lk.byte_done <= 1'b0;
      lk.ninth_done <= 1'b0;
    end else begin
      lk.start <= start_seen;
      lk.stop <= stop_seen;
      lk.byte_done <= rise & last_bit;
      lk.ninth_done <= rise & ack_slot;
    end
  end

  // falling clock edge is passed on at once to keep sda setup time
  assign lk.scl_fall = ~scl_now & scl_prev;

  always_ff @(posedge clk) begin
    if (rst || start_seen || stop_seen) begin
      lk.bit_cnt <= 4'h0;
    end else if (rise) begin
      lk.bit_cnt <= ack_slot ? 4'h0 : lk.bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift <= 7'h00;
      lk.rx_byte <= 8'h00;
      lk.ack_bit <= 1'b1;
    end else if (rise) begin
      if (last_bit) begin
        lk.rx_byte <= {shift, sda_now};
      end else if (ack_slot) begin
        lk.ack_bit <= sda_now;
      end else begin
        shift <= {shift[5:0], sda_now};
      end
    end
  end

  assign sda_oe = lk.sda_low;
endmodule // smbus_link

// [verilog/measurement_sequencer.sv]
// round robin measurement store with offset and limit comparison
`timescale 1ns/1ps
module measurement_sequencer
  import smbus_mon_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic meas_valid,
  input wire logic [7:0] meas_value,
  input wire logic [NUM_TEMP-1:0][7:0] offsets,
  input wire logic [NUM_CH-1:0][7:0] high_lim,
  input wire logic [NUM_CH-1:0][7:0] low_lim,
  output logic [2:0] channel,
  output logic [NUM_CH-1:0][7:0] values,
  output logic [NUM_CH-1:0] over_hi,
  output logic [NUM_CH-1:0] over_lo
);
  function automatic logic [7:0] add_offset(input logic [7:0] raw,
                                            input logic [7:0] off);
    logic signed [8:0] sum;
    sum = $signed({raw[7], raw}) + $signed({off[7], off});
    if (sum > 9'sh07f) add_offset = 8'h7f;
    else if (sum < -9'sh080) add_offset = 8'h80;
    else add_offset = sum[7:0];
  endfunction

  function automatic logic above(input logic [7:0] a, input logic [7:0] b,
                                 input logic signed_cmp);
    above = signed_cmp ? ($signed(a) > $signed(b)) : (a > b);
  endfunction

  wire is_temp = (channel >= 3'(TEMP_FIRST));
  wire [2:0] temp_idx = channel - 3'(TEMP_FIRST);
  wire [1:0] off_sel = is_temp ? temp_idx[1:0] : 2'h0;
  wire last_ch = (channel == 3'(NUM_CH - 1));
  wire [7:0] adjusted =
    is_temp ? add_offset(meas_value, offsets[off_sel]) : meas_value;

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      channel <= 3'h0;
    end else if (meas_valid) begin
      channel <= last_ch ? 3'h0 : channel + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      values <= '0;
      over_hi <= '0;
      over_lo <= '0;
    end else if (run && meas_valid) begin
      values[channel] <= adjusted;
      over_hi[channel] <= above(adjusted, high_lim[channel], is_temp);
      over_lo[channel] <= above(low_lim[channel], adjusted, is_temp);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_seq_wrap;
    run && meas_valid && last_ch |=> channel == 3'h0;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap)
    else $error("channel did not wrap after last input");

  property p_seq_offset;
    run && meas_valid && channel == 3'(TEMP_FIRST)
      |=> values[TEMP_FIRST] ==
        add_offset($past(meas_value), $past(offsets[0]));
  endproperty
  a_seq_offset: assert property (p_seq_offset)
    else $error("first temperature stored without its offset");

  property p_seq_over;
    run && meas_valid && !is_temp && meas_value > high_lim[channel]
      |=> over_hi[$past(channel)];
  endproperty
  a_seq_over: assert property (p_seq_over)
    else $error("voltage above high limit not flagged");

  c_seq_cycle: cover property (run && meas_valid && last_ch);
endmodule // measurement_sequencer

// [tb/smbus_master_model.sv]
// behavioural smbus master driving the clock line directly and the open-drain data line
`timescale 1ns/1ps
module smbus_master_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // half of the 32 ns link period
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // one bit is a low half then a high half; data moves with the clock fall
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r,
                         output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(1'b1, nak);
  endtask
endmodule // smbus_master_model

// [tb/tb_smbus_monitor_top.sv]
// register and address tests of the smbus monitor front end
`timescale 1ns/1ps
module tb_smbus_monitor_top;
  import smbus_mon_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic addr_en = 1'b0;
  logic addr_sel = 1'b1;
  logic meas_valid = 1'b0;
  logic [7:0] meas_value = 8'h00;
  logic [6:0] dev = 7'h2d;
  logic [7:0] rv;
  logic ak;
  logic [7:0] mv [5] = '{8'h10, 8'h80, 8'h10, 8'h20, 8'h20};
  wire scl, sda_low, sda_oe, sel_oe, a5_oe, am_oe, scale;
  wire [2:0] chan;
  wire sda_line = ~(sda_low | sda_oe);
  int n_errors = 0;
  int cmp_count = 0;
  always #2 clk_sys = ~clk_sys;
  smbus_monitor_top smbus_monitor_top_i (
    .CLK_SYS(clk_sys), .RESET(reset), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(), .SDA_OE(sda_oe), .ADDR_ENABLE_IN(addr_en),
    .ADDR_SELECT_IN(addr_sel & ~sel_oe), .ADDR_SELECT_OUT(),
    .ADDR_SELECT_OE(sel_oe), .ALERT_FIVE_OUT(), .ALERT_FIVE_OE(a5_oe),
    .ALERT_MON_OUT(), .ALERT_MON_OE(am_oe), .MEAS_VALID(meas_valid),
    .MEAS_VALUE(meas_value), .MEAS_CHANNEL(chan),
    .SUPPLY_SCALE_5V(scale));
  smbus_master_model smbus_master_model_i (
    .clk(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                    input bit two, output logic nak);
    logic n1, n2, n3;
    logic [7:0] r;
    smbus_master_model_i.start();
    smbus_master_model_i.byte_io({a, 1'b0}, r, n1);
    smbus_master_model_i.byte_io(p, r, n2);
    n3 = 1'b0;
    if (two) begin
      smbus_master_model_i.byte_io(d, r, n3);
    end
    smbus_master_model_i.stop();
    nak = n1 | n2 | n3;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    logic n;
    logic [7:0] r;
    wr(dev, p, 8'h00, 1'b0, n);
    smbus_master_model_i.start();
    smbus_master_model_i.byte_io({dev, 1'b1}, r, n);
    smbus_master_model_i.byte_io(8'hff, v, n);
    smbus_master_model_i.stop();
  endtask
  task automatic meas(input logic [7:0] v);
    @(posedge clk_sys);
    #1 meas_valid = 1'b1;
    meas_value = v;
    @(posedge clk_sys);
    #1 meas_valid = 1'b0;
  endtask
  task automatic do_reset(input logic en);
    reset = 1'b1;
    addr_en = en;
    repeat (10) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    do_reset(1'b0);
    wr(ADDR_DEFAULT, REG_CONFIG_ONE, 8'h00, 1'b1, ak);
    check({7'h0, ak}, 8'h01, "default address answered");
    wr(7'h2d, REG_CONFIG_ONE, 8'h81, 1'b1, ak);
    check({7'h0, ak}, 8'h00, "select address refused");
    addr_sel = 1'b0;
    wr(ADDR_SEL_BASE, REG_CONFIG_ONE, 8'h00, 1'b1, ak);
    check({7'h0, ak}, 8'h01, "address changed after latch");
    check({7'h0, scale}, 8'h01, "scale bit not applied");
    rd(REG_CONFIG_ONE, rv);
    check(rv, 8'h81, "config readback");
    $display("address and register test done");
    wr(dev, REG_LOW_BASE, 8'h40, 1'b1, ak);
    wr(dev, REG_OFFSET_BASE, 8'h05, 1'b1, ak);
    wr(dev, REG_HIGH_BASE + 8'h01, 8'h70, 1'b1, ak);
    for (int i = 0; i < 5; i++) begin
      check({5'h0, chan}, i[7:0], "channel order");
      meas(mv[i]);
    end
    check({5'h0, chan}, 8'h00, "channel wrap");
    rd(REG_VALUE_BASE + 8'h02, rv);
    check(rv, 8'h15, "offset not added");
    rd(REG_STATUS, rv);
    check(rv, 8'h03, "status value");
    $display("measurement test done");
    wr(dev, REG_PIN_CFG, 8'h01, 1'b1, ak);
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h0, a5_oe}, 8'h01, "alert not driven");
    check({7'h0, am_oe}, 8'h00, "wrong alert pin");
    wr(dev, REG_MASK, 8'h03, 1'b1, ak);
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h0, a5_oe}, 8'h00, "masked alert driven");
    wr(dev, REG_HIGH_BASE + 8'h02, 8'h00, 1'b1, ak);
    wr(dev, REG_PIN_CFG, 8'h05, 1'b1, ak);
    check({7'h0, sel_oe}, 8'h00, "overtemp driven early");
    for (int i = 0; i < 3; i++) begin
      meas(mv[i]);
    end
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h0, sel_oe}, 8'h01, "overtemp not driven");
    $display("alert test done");
    do_reset(1'b1);
    wr(ADDR_DEFAULT, REG_CONFIG_ONE, 8'h00, 1'b0, ak);
    check({7'h0, ak}, 8'h00, "default address refused");
    wr(7'h2d, REG_CONFIG_ONE, 8'h00, 1'b0, ak);
    check({7'h0, ak}, 8'h01, "other address answered");
    $display("default address test done");
    report_and_stop();
  end
endmodule // tb_smbus_monitor_top
